//--- core/iepd_pkg.sv
// iepd_pkg: shared constants for the input endpoint descriptor block
// assumes a 16-bit byte address port and 8-bit register data
package iepd_pkg;
  localparam int NUM_EP = 3;
  // descriptor bases for input endpoints 1..3, eight bytes apart
  localparam logic [15:0] EP1_BASE = 16'hFF48;
  localparam logic [15:0] EP2_BASE = 16'hFF50;
  localparam logic [15:0] EP3_BASE = 16'hFF58;
  localparam logic [2:0] OFS_CONFIG = 3'h0;
  localparam logic [2:0] OFS_X_BASE = 3'h1;
  // interrupt block of our own, beside the descriptors
  localparam logic [15:0] IRQ_STATUS_ADDR = 16'hFF60;
  localparam logic [15:0] IRQ_MASK_ADDR = 16'hFF61;
  // configuration field positions
  localparam int BIT_ENABLE = 7;
  localparam int BIT_ISO = 6;
  localparam int BIT_TOGGLE = 5;
  localparam int BIT_DOUBLE_BUFFER_ENABLE = 4;
  localparam int BIT_STALL = 3;
  localparam int BIT_IE = 2;
  localparam logic [7:0] CONFIG_WMASK = 8'hFC;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] X_BASE_RESET = 8'h00;
  localparam logic [2:0] ADDR_PAD = 3'h0;
  // answers to the buffer manager
  typedef enum logic [1:0] {
    IEPD_ANS_OFF = 2'h0,
    IEPD_ANS_DATA = 2'h1,
    IEPD_ANS_STALL = 2'h3
  } iepd_ans_t;
endpackage

//--- core/iepd_addr_gen.sv
// iepd_addr_gen: forms the 11-bit buffer start address for one endpoint
// assumes inputs are registered state on the same clock
`timescale 1ns/1ns
`default_nettype none
module iepd_addr_gen
(
  input wire logic [7:0] x_base,
  input wire logic [7:0] y_base,
  input wire logic double_buffer_enable,
  input wire logic toggle,
  output logic [10:0] start_addr
);
  // toggle picks y only in double-buffer mode; low bits padded with zeros
  always_comb
  begin
    if (double_buffer_enable && toggle)
      start_addr = {y_base, iepd_pkg::ADDR_PAD};
    else
      start_addr = {x_base, iepd_pkg::ADDR_PAD};
  end
endmodule
`default_nettype wire

//--- core/iepd_irq.sv
// iepd_irq: sticky event bits, mask, level interrupt output
// assumes one-cycle event pulses and write-one-to-clear from software
`timescale 1ns/1ns
`default_nettype none
module iepd_irq
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [2:0] event_pulse,
  input wire logic status_wr,
  input wire logic mask_wr,
  input wire logic [2:0] wdata,
  output logic [2:0] status,
  output logic [2:0] mask,
  output logic irq
);
  typedef struct packed {
    logic [2:0] status;
    logic [2:0] mask;
  } iepd_irq_state_t;
  iepd_irq_state_t state_reg;
  iepd_irq_state_t state_next;
  // set wins over a clear in the same cycle so no event is lost
  always_comb
  begin
    state_next = state_reg;
    if (status_wr)
      state_next.status = state_reg.status & ~wdata;
    state_next.status = state_next.status | event_pulse;
    if (mask_wr)
      state_next.mask = wdata;
  end
  always_ff @(posedge core_clk)
  begin
    if (reset)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end
  assign status = state_reg.status;
  assign mask = state_reg.mask;
  assign irq = |(state_reg.status & state_reg.mask);
endmodule
`default_nettype wire

//--- core/iepd_top.sv
// iepd_top: input endpoint 1..3 descriptor registers (config, x base)
// assumes firmware on a plain strobe port and a buffer manager on the same clock
// How it works
// - endpoint ignored by the buffer manager while its enable bit 7 is clear.
// - toggle bit 5 shows the current DATA0/DATA1 sequence state.
// - without double buffering only x is used; with it toggle selects buffer.
// - stall bit 3 resets to zero, set by manager, firmware may set or clear.
// - firmware-set stall answers next host transaction with STALL, then clears itself.
// - completion interrupt enable bit 2 raises an interrupt per completed transaction; here it sets a status bit and irq also needs its mask bit set.
// - x base holds address bits 10..3; three zero bits pad it to eleven.
// - the programmed base is the start address of each transaction.
// - the x base is never changed when a transaction ends.
// - configuration entries sit at FF48h, FF50h and FF58h, eight bytes apart.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module iepd_top
(
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // buffer manager side, one-hot endpoint select (bit 0 = endpoint 1)
  input wire logic [2:0] bm_ep_sel,
  input wire logic bm_start,
  input wire logic bm_done,
  input wire logic bm_stall_set,
  input wire logic [7:0] bm_y_base,
  output logic [2:0] bm_ep_enabled,
  output logic [1:0] bm_answer,
  output logic [10:0] bm_start_addr,
  output logic bm_data_pid_is_1,
  // interrupt
  output logic irq
);
  typedef struct packed {
    logic [2:0][7:0] cfg;
    logic [2:0][7:0] x_base;
    logic [2:0] stall_by_fw;
    logic [7:0] rdata;
    logic [1:0] answer;
    logic [10:0] start_addr;
    logic pid1;
  } iepd_state_t;
  iepd_state_t state_reg;
  iepd_state_t state_next;
  logic [2:0] hit_cfg;
  logic [2:0] hit_xb;
  logic [2:0] done_evt;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [10:0] sel_addr;
  logic [1:0] sel_idx;
  logic [15:0] ep_base [3];
  assign ep_base[0] = iepd_pkg::EP1_BASE;
  assign ep_base[1] = iepd_pkg::EP2_BASE;
  assign ep_base[2] = iepd_pkg::EP3_BASE;
  // address decode per endpoint descriptor
  genvar gi;
  generate
    for (gi = 0; gi < iepd_pkg::NUM_EP; gi++)
    begin : g_dec
      assign hit_cfg[gi] = (reg_addr == (ep_base[gi] | {13'h0000, iepd_pkg::OFS_CONFIG}));
      assign hit_xb[gi] = (reg_addr == (ep_base[gi] | {13'h0000, iepd_pkg::OFS_X_BASE}));
      assign bm_ep_enabled[gi] = state_reg.cfg[gi][iepd_pkg::BIT_ENABLE];
      // completion counts only for an enabled endpoint with interrupt enabled
      assign done_evt[gi] = bm_done && bm_ep_sel[gi] && state_reg.cfg[gi][iepd_pkg::BIT_ENABLE]
        && state_reg.cfg[gi][iepd_pkg::BIT_IE];
    end
  endgenerate
  // selected endpoint index from one-hot select
  always_comb
  begin
    sel_idx = 2'h0;
    if (bm_ep_sel[1])
      sel_idx = 2'h1;
    else if (bm_ep_sel[2])
      sel_idx = 2'h2;
  end
  iepd_addr_gen u_addr
  (
    .x_base(state_reg.x_base[sel_idx]),
    .y_base(bm_y_base),
    .double_buffer_enable(state_reg.cfg[sel_idx][iepd_pkg::BIT_DOUBLE_BUFFER_ENABLE]),
    .toggle(state_reg.cfg[sel_idx][iepd_pkg::BIT_TOGGLE]),
    .start_addr(sel_addr)
  );
  iepd_irq u_irq
  (
    .core_clk(core_clk),
    .reset(reset),
    .event_pulse(done_evt),
    .status_wr(reg_wr && reg_addr == iepd_pkg::IRQ_STATUS_ADDR),
    .mask_wr(reg_wr && reg_addr == iepd_pkg::IRQ_MASK_ADDR),
    .wdata(reg_wdata[2:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );
  // register writes, manager updates, transaction answers
  always_comb
  begin
    state_next = state_reg;
    state_next.rdata = 8'h00;
    for (int i = 0; i < iepd_pkg::NUM_EP; i++)
    begin
      if (reg_wr && hit_cfg[i])
      begin
        // reserved bits are dropped so they can never steer anything
        state_next.cfg[i] = reg_wdata & iepd_pkg::CONFIG_WMASK;
        state_next.stall_by_fw[i] = reg_wdata[iepd_pkg::BIT_STALL];
      end
      if (reg_wr && hit_xb[i])
        state_next.x_base[i] = reg_wdata; // only firmware writes it
      if (bm_ep_sel[i] && state_reg.cfg[i][iepd_pkg::BIT_ENABLE])
      begin
        // successful completion advances the data sequence
        if (bm_done)
          state_next.cfg[i][iepd_pkg::BIT_TOGGLE] = ~state_reg.cfg[i][iepd_pkg::BIT_TOGGLE];
        if (bm_stall_set)
        begin
          state_next.cfg[i][iepd_pkg::BIT_STALL] = 1'b1;
          state_next.stall_by_fw[i] = 1'b0;
        end
        // firmware stall is one-shot: answered once, then cleared
        if (bm_start && state_reg.stall_by_fw[i])
        begin
          state_next.cfg[i][iepd_pkg::BIT_STALL] = 1'b0;
          state_next.stall_by_fw[i] = 1'b0;
        end
      end
      if (reg_rd && hit_cfg[i])
        state_next.rdata = state_reg.cfg[i];
      if (reg_rd && hit_xb[i])
        state_next.rdata = state_reg.x_base[i];
    end
    if (reg_rd && reg_addr == iepd_pkg::IRQ_STATUS_ADDR)
      state_next.rdata = {5'h00, irq_status};
    if (reg_rd && reg_addr == iepd_pkg::IRQ_MASK_ADDR)
      state_next.rdata = {5'h00, irq_mask};
    // answer registered one cycle after the start request
    state_next.answer = iepd_pkg::IEPD_ANS_OFF;
    if (bm_start && state_reg.cfg[sel_idx][iepd_pkg::BIT_ENABLE])
    begin
      if (state_reg.cfg[sel_idx][iepd_pkg::BIT_STALL])
        state_next.answer = iepd_pkg::IEPD_ANS_STALL;
      else
        state_next.answer = iepd_pkg::IEPD_ANS_DATA;
      state_next.start_addr = sel_addr;
      state_next.pid1 = state_reg.cfg[sel_idx][iepd_pkg::BIT_TOGGLE];
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_reg <= '0;
      for (int i = 0; i < iepd_pkg::NUM_EP; i++)
      begin
        state_reg.cfg[i] <= iepd_pkg::CONFIG_RESET; // stall starts clear
        state_reg.x_base[i] <= iepd_pkg::X_BASE_RESET;
      end
    end
    else
      state_reg <= state_next;
  end
  assign reg_rdata = state_reg.rdata;
  assign bm_answer = state_reg.answer;
  assign bm_start_addr = state_reg.start_addr;
  assign bm_data_pid_is_1 = state_reg.pid1;
endmodule
`default_nettype wire

//--- bench/iepd_monitor.sv
// iepd_monitor: port-level checks on iepd_top
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module iepd_monitor
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] bm_ep_sel,
  input wire logic bm_start,
  input wire logic bm_done,
  input wire logic bm_stall_set,
  input wire logic [7:0] bm_y_base,
  input wire logic [2:0] bm_ep_enabled,
  input wire logic [1:0] bm_answer,
  input wire logic [10:0] bm_start_addr,
  input wire logic bm_data_pid_is_1,
  input wire logic irq
);
  // one domain, so clock and reset are named once
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  a_off_answer: assert property (bm_start && !(|(bm_ep_sel & bm_ep_enabled)) |=> bm_answer == 2'h0)
    else $error("answer to an off endpoint");
  a_answer_cause: assert property (bm_answer != 2'h0 |-> $past(bm_start))
    else $error("answer without a start");
  a_addr_hold: assert property (!bm_start |=> $stable(bm_start_addr) && $stable(bm_data_pid_is_1))
    else $error("start address moved");
  a_addr_pad: assert property (bm_start_addr[2:0] == 3'h0)
    else $error("address not aligned");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_enable_set: assert property (reg_wr && reg_addr == 16'hFF48 && reg_wdata[7] |=> bm_ep_enabled[0])
    else $error("enable not taken");
  a_irq_cause: assert property ($rose(irq) |-> $past(bm_done) || $past(reg_wr))
    else $error("interrupt without cause");
  a_answer_code: assert property (bm_answer != 2'h2)
    else $error("bad answer code");
  c_data: cover property (bm_answer == 2'h1);
  c_stall: cover property (bm_answer == 2'h3);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

//--- bench/iepd_bm_model.sv
// iepd_bm_model: buffer manager stand-in running host IN transactions
// assumes the bench calls xact after reset, one transaction at a time
`timescale 1ns/1ns
`default_nettype none
module iepd_bm_model
(
  input wire logic core_clk,
  output logic [2:0] bm_ep_sel,
  output logic bm_start,
  output logic bm_done,
  output logic bm_stall_set
);
  initial {bm_ep_sel, bm_start, bm_done, bm_stall_set} = 6'h00;
  // start, a gap of gap cycles, then done or stall; select inverted when idle
  task automatic xact(input logic [2:0] sel, input logic fin, input logic stl, input int gap);
    @(posedge core_clk);
    bm_ep_sel <= sel;
    bm_start <= 1'b1;
    @(posedge core_clk);
    bm_start <= 1'b0;
    repeat (gap) @(posedge core_clk);
    bm_done <= fin;
    bm_stall_set <= stl;
    @(posedge core_clk);
    {bm_done, bm_stall_set} <= 2'h0;
    bm_ep_sel <= ~sel;
  endtask
endmodule
`default_nettype wire

//--- bench/iepd_top_tb.sv
// iepd_top_tb: register, transaction and interrupt scenarios
// assumes the buffer manager model drives the transaction side
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h", $time, a); end end
module iepd_top_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, y = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_rdata, x;
  logic [2:0] sel, on;
  logic start, done, stl, pid, irq, rd_d, st_d;
  logic [1:0] ans;
  logic [10:0] sa;
  logic [13:0] n, aq[$];
  logic [7:0] rq[$];
  logic [15:0] b;
  logic [31:0] seed = 32'h6DA03CE4;
  int fail_count = 0;
  int check_count = 0;
  iepd_top i_iepd_top (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bm_ep_sel(sel), .bm_start(start), .bm_done(done),
    .bm_stall_set(stl), .bm_y_base(y), .bm_ep_enabled(on), .bm_answer(ans), .bm_start_addr(sa),
    .bm_data_pid_is_1(pid), .irq(irq));
  iepd_bm_model i_iepd_bm_model (.core_clk(core_clk), .bm_ep_sel(sel), .bm_start(start), .bm_done(done),
    .bm_stall_set(stl));
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge core_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  // note the expected answer, then let the model run one host IN
  task automatic go(input int ep, input logic [13:0] e, input logic fin, input logic st);
    aq.push_back(e);
    i_iepd_bm_model.xact(3'h1 << ep, fin, st, ep);
  endtask
  task automatic final_report();
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // results stand one cycle after the request; compare them mid-cycle
  always @(posedge core_clk) {rd_d, st_d} <= {reg_rd, start};
  always @(negedge core_clk)
  begin
    if (rd_d)
      `CHK(reg_rdata, rq.pop_front())
    if (st_d)
    begin
      n = aq.pop_front();
      `CHK(ans, n[13:12])
      if (n[13:12] == 2'h1)
        `CHK({sa, pid}, n[11:0])
    end
  end
  initial
  begin
    #100000;
    fail_count++;
    final_report();
  end
  initial
  begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    wr(16'hFF4F, 8'hFF);
    rd(16'hFF4F, 8'h00);
    for (int ep = 0; ep < 3; ep++)
    begin
      b = iepd_pkg::EP1_BASE + 16'(8 * ep);
      x = rnd();
      y <= rnd();
      rd(b, 8'h00);
      `CHK(on[ep], 1'b0)
      go(ep, 14'h0, 1'b1, 1'b0);
      wr(b + 16'h1, x);
      wr(b, 8'h87); // iso bit 6 kept clear
      rd(b, 8'h84);
      `CHK(on[ep], 1'b1)
      go(ep, {2'h1, x, 4'h0}, 1'b1, 1'b0);
      rd(b, 8'hA4);
      wr(b, 8'hB4);
      go(ep, {2'h1, y, 4'h1}, 1'b1, 1'b0);
      rd(b, 8'h94);
      go(ep, {2'h1, x, 4'h0}, 1'b0, 1'b0);
      rd(b + 16'h1, x);
      wr(b, 8'h88);
      go(ep, {2'h3, 12'h0}, 1'b0, 1'b0);
      rd(b, 8'h80);
      go(ep, {2'h1, x, 4'h0}, 1'b0, 1'b1);
      rd(b, 8'h88);
    end
    rd(iepd_pkg::IRQ_STATUS_ADDR, 8'h07);
    @(negedge core_clk);
    `CHK(irq, 1'b0)
    wr(iepd_pkg::IRQ_MASK_ADDR, 8'h02);
    @(negedge core_clk);
    `CHK(irq, 1'b1)
    wr(iepd_pkg::IRQ_STATUS_ADDR, 8'h02);
    rd(iepd_pkg::IRQ_STATUS_ADDR, 8'h05);
    @(negedge core_clk);
    `CHK(irq, 1'b0)
    repeat (4) @(posedge core_clk);
    final_report();
  end
endmodule
bind iepd_top iepd_monitor i_iepd_monitor (.*);
`default_nettype wire
